// *** rtl/gpio_port_defines.svh ***
`ifndef GPIO_PORT_DEFINES_SVH
`define GPIO_PORT_DEFINES_SVH

`define PIN_COUNT            16
`define ADDR_WIDTH           12
`define OFF_PIN_DIRECTION    12'h400
`define OFF_PIN_DATA         12'h404
`define OFF_PIN_IRQ_ENABLE   12'h408
`define OFF_PIN_IRQ_STATUS   12'h40C
`define OFF_PIN_IRQ_CLEAR    12'h410
`define RESET_PIN_DIRECTION  16'h0000
`define RESET_PIN_DATA       16'h0000
`define RESET_PIN_IRQ_ENABLE 16'h0000
`define ZERO_PINS            16'h0000
`define ZERO_UPPER           16'h0000
`define ZERO_WORD            32'h0000_0000
`define DIR_OUTPUT           1'h0

`endif

// *** rtl/gpio_port_pkg.sv ***
package gpio_port_pkg;
  typedef struct packed {
    logic        read;
    logic        write;
    logic [11:0] address;
    logic [31:0] writedata;
  } bus_req_t;

  typedef struct packed {
    logic [15:0] level;
    logic [15:0] drive_n;
  } pin_out_t;

  typedef enum logic [2:0] {
    st_idle   = 3'b001,
    st_answer = 3'b010,
    st_done   = 3'b100
  } bus_state_t;
endpackage

// *** rtl/pin_sync.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "gpio_port_defines.svh"

module pin_sync (
  // clock and reset
  input  wire logic                   sys_clk,
  input  wire logic                   rst,
  // raw pins in, stable levels out
  input  wire logic [`PIN_COUNT-1:0]  raw,
  output var  logic [`PIN_COUNT-1:0]  stable,
  output var  logic [`PIN_COUNT-1:0]  toggled
);

  logic [`PIN_COUNT-1:0] stage1;
  logic [`PIN_COUNT-1:0] stage2;
  logic [`PIN_COUNT-1:0] stage3;

  // ************
  // per-pin chain
  // ************
  genvar i;
  generate
    for (i = 0; i < `PIN_COUNT; i = i + 1) begin : g_pin
      always_ff @(posedge sys_clk) begin
        if (rst) begin
          stage1[i]  <= 1'b0;
          stage2[i]  <= 1'b0;
          stage3[i]  <= 1'b0;
          stable[i]  <= 1'b0;
          toggled[i] <= 1'b0;
        end else begin
          stage1[i] <= raw[i];
          stage2[i] <= stage1[i];
          stage3[i] <= stage2[i];
          // change only counts once stages two and three agree
          toggled[i] <= 1'b0;
          if (stage2[i] == stage3[i]) begin
            stable[i]  <= stage3[i];
            toggled[i] <= (stage3[i] != stable[i]);
          end
        end
      end
    end
  endgenerate

endmodule
`default_nettype wire

// *** rtl/general_pin_port.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "gpio_port_defines.svh"

module general_pin_port (
  // clock and reset
  input  wire logic                    sys_clk,
  input  wire logic                    rst,
  // avalon-mm slave
  input  wire logic [`ADDR_WIDTH-1:0]  avs_address,
  input  wire logic                    avs_read,
  input  wire logic                    avs_write,
  input  wire logic [31:0]             avs_writedata,
  input  wire logic [3:0]              avs_byteenable,
  output var  logic [31:0]             avs_readdata,
  output var  logic                    avs_waitrequest,
  output var  logic [1:0]              avs_response,
  // general purpose pins
  input  wire logic [`PIN_COUNT-1:0]   general_purpose_pin_in,
  output var  logic [`PIN_COUNT-1:0]   general_purpose_pin_out,
  output var  logic [`PIN_COUNT-1:0]   general_purpose_pin_oe_n,
  // interrupt
  output var  logic                    irq
);

  // ************
  // registers
  // ************
  logic [`PIN_COUNT-1:0] pin_direction_bits;
  logic [`PIN_COUNT-1:0] pin_level_bits;
  logic [`PIN_COUNT-1:0] pin_irq_enable_bits;
  logic [`PIN_COUNT-1:0] pin_irq_status;
  logic [`PIN_COUNT-1:0] pin_stable;
  logic [`PIN_COUNT-1:0] pin_toggled;
  gpio_port_pkg::bus_req_t   req;
  gpio_port_pkg::bus_state_t state;
  logic [15:0]           wmask;
  logic                  do_write;
  logic                  hit;

  assign req.read      = avs_read;
  assign req.write     = avs_write;
  assign req.address   = avs_address;
  assign req.writedata = avs_writedata;
  assign wmask = {{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
  assign do_write = req.write && (state == gpio_port_pkg::st_answer);

  // ************
  // input sampling
  // ************
  pin_sync u_sync (
    .sys_clk (sys_clk),
    .rst     (rst),
    .raw     (general_purpose_pin_in),
    .stable  (pin_stable),
    .toggled (pin_toggled)
  );

  // ************
  // bus handshake
  // ************
  // one wait cycle, then answer; done state drops the request edge
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state           <= gpio_port_pkg::st_idle;
      avs_waitrequest <= 1'b1;
    end else begin
      case (state)
        gpio_port_pkg::st_idle: begin
          if (req.read || req.write) begin
            state           <= gpio_port_pkg::st_answer;
            avs_waitrequest <= 1'b0;
          end
        end
        gpio_port_pkg::st_answer: begin
          state           <= gpio_port_pkg::st_done;
          avs_waitrequest <= 1'b1;
        end
        gpio_port_pkg::st_done: begin
          state <= gpio_port_pkg::st_idle;
        end
        default: begin
          state           <= gpio_port_pkg::st_idle;
          avs_waitrequest <= 1'b1;
        end
      endcase
    end
  end

  // ************
  // direction and enable
  // ************
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pin_direction_bits  <= `RESET_PIN_DIRECTION;
      pin_irq_enable_bits <= `RESET_PIN_IRQ_ENABLE;
    end else if (do_write) begin
      if (req.address == `OFF_PIN_DIRECTION)
        pin_direction_bits <= (pin_direction_bits & ~wmask) | (req.writedata[15:0] & wmask);
      if (req.address == `OFF_PIN_IRQ_ENABLE)
        pin_irq_enable_bits <= (pin_irq_enable_bits & ~wmask) | (req.writedata[15:0] & wmask);
    end
  end

  // ************
  // output data latch
  // ************
  // only output-direction bits take the write
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pin_level_bits <= `RESET_PIN_DATA;
    end else if (do_write && req.address == `OFF_PIN_DATA) begin
      pin_level_bits <= (pin_level_bits & ~(wmask & ~pin_direction_bits))
                      | (req.writedata[15:0] & wmask & ~pin_direction_bits);
    end
  end

  // ************
  // pin drivers
  // ************
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      general_purpose_pin_out  <= `ZERO_PINS;
      general_purpose_pin_oe_n <= ~`ZERO_PINS;
    end else begin
      general_purpose_pin_out  <= pin_level_bits;
      general_purpose_pin_oe_n <= pin_direction_bits;
    end
  end

  // ************
  // interrupt status
  // ************
  // set beats a simultaneous clear so no edge is lost
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pin_irq_status <= `ZERO_PINS;
    end else begin
      pin_irq_status <= (pin_irq_status
                         & ~((do_write && req.address == `OFF_PIN_IRQ_CLEAR) ? (req.writedata[15:0] & wmask)
                                                                            : `ZERO_PINS))
                        | (pin_toggled & pin_irq_enable_bits);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(pin_irq_status & pin_irq_enable_bits);
    end
  end

  // ************
  // read data
  // ************
  always_comb begin
    hit = (req.address == `OFF_PIN_DIRECTION) || (req.address == `OFF_PIN_DATA)
       || (req.address == `OFF_PIN_IRQ_ENABLE) || (req.address == `OFF_PIN_IRQ_STATUS)
       || (req.address == `OFF_PIN_IRQ_CLEAR);
  end

  // read value sampled on the idle-to-answer edge, so it stands while waitrequest is low
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      avs_readdata <= `ZERO_WORD;
      avs_response <= 2'h0;
    end else if (state == gpio_port_pkg::st_idle && (req.read || req.write)) begin
      avs_response <= hit ? 2'h0 : 2'h3;
      avs_readdata <= `ZERO_WORD;
      if (req.read) begin
        case (req.address)
          `OFF_PIN_DIRECTION:  avs_readdata <= {`ZERO_UPPER, pin_direction_bits};
          // pins read back from the sampled level whatever their direction
          `OFF_PIN_DATA:       avs_readdata <= {`ZERO_UPPER, pin_stable};
          `OFF_PIN_IRQ_ENABLE: avs_readdata <= {`ZERO_UPPER, pin_irq_enable_bits};
          `OFF_PIN_IRQ_STATUS: avs_readdata <= {`ZERO_UPPER, pin_irq_status};
          default:             avs_readdata <= `ZERO_WORD;
        endcase
      end
    end
  end

endmodule
`default_nettype wire

// *** bench/pin_far_end.sv ***
`timescale 1ns/1ps
`default_nettype none
module pin_far_end (
  // pin side of the port
  input  wire logic [15:0] ext_level,
  input  wire logic [15:0] pin_out,
  input  wire logic [15:0] pin_oe_n,
  output logic      [15:0] pin_in
);
  // driven pins read their own level back, released pins see the outside
  assign pin_in = (pin_out & ~pin_oe_n) | (ext_level & pin_oe_n);
endmodule
`default_nettype wire

// *** bench/general_pin_port_sva.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "gpio_port_defines.svh"
module general_pin_port_sva (
  input wire logic        sys_clk,
  input wire logic        rst,
  input wire logic [11:0] avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic [1:0]  avs_response,
  input wire logic [15:0] general_purpose_pin_out,
  input wire logic [15:0] general_purpose_pin_oe_n,
  input wire logic        irq
);
  // ***
  // checks
  // ***
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  logic [15:0] wval;
  wire logic mapped = avs_address inside {12'h400, 12'h404, 12'h408, 12'h40C, 12'h410};
  wire logic wr_ok  = avs_write && !avs_waitrequest;
  wire logic dat_wr = wr_ok && avs_address == `OFF_PIN_DATA;
  wire logic dir_wr = wr_ok && avs_address == `OFF_PIN_DIRECTION;
  always_ff @(posedge sys_clk) begin
    if (dat_wr) begin
      wval <= avs_writedata[15:0];
    end
  end
  a_upper_zero: assert property (avs_readdata[31:16] == 16'h0000)
    else $error("upper read bits not zero");
  a_answer_once: assert property ($rose(avs_read | avs_write) |=> !avs_waitrequest ##1 avs_waitrequest)
    else $error("bus answer timing wrong");
  a_unmapped_resp: assert property (!avs_waitrequest |-> (avs_response == 2'h3) == !mapped)
    else $error("response code wrong");
  a_read_stands: assert property (avs_waitrequest && $past(avs_waitrequest) |-> $stable(avs_readdata))
    else $error("read data moved while idle");
  a_drive_level: assert property (dat_wr |-> ##[1:3] ((general_purpose_pin_out ^ wval) & ~general_purpose_pin_oe_n) == 16'h0000)
    else $error("output pin level differs from write");
  a_input_kept: assert property (((general_purpose_pin_out ^ $past(general_purpose_pin_out)) & general_purpose_pin_oe_n & $past(general_purpose_pin_oe_n)) == 16'h0000)
    else $error("input pin stored value changed");
  a_oe_follows: assert property (!$stable(general_purpose_pin_oe_n) |-> $past(dir_wr) || $past(dir_wr, 2) || $past(dir_wr, 3) || $past(rst) || $past(rst, 2))
    else $error("enable changed without direction write");
  a_irq_clear: assert property ($fell(irq) |-> $past(avs_write) || $past(avs_write, 2) || $past(avs_write, 3))
    else $error("interrupt dropped without a write");
  c_read: cover property (avs_read && !avs_waitrequest);
  c_irq: cover property ($rose(irq));
  c_unmapped: cover property (avs_response == 2'h3);
endmodule
bind general_pin_port general_pin_port_sva chk_u (.sys_clk, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
  .avs_readdata, .avs_waitrequest, .avs_response, .general_purpose_pin_out, .general_purpose_pin_oe_n, .irq);
`default_nettype wire

// *** bench/general_pin_port_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "gpio_port_defines.svh"
module general_pin_port_tb;
  logic        sys_clk = 1'b0;
  logic        rst     = 1'b1;
  logic        rd      = 1'b0;
  logic        wr      = 1'b0;
  logic        irq;
  logic        wreq;
  logic [1:0]  resp;
  logic [11:0] addr    = 12'h000;
  logic [31:0] wdata   = 32'h0000_0000;
  logic [31:0] seed    = 32'hA21A;
  logic [31:0] rdata;
  logic [31:0] q;
  logic [15:0] ext     = 16'h0000;
  logic [15:0] stored  = 16'h0000;
  logic [15:0] dir;
  logic [15:0] pin_in;
  logic [15:0] pin_out;
  logic [15:0] oe_n;
  int          n_fail  = 0;
  int          checks_done = 0;
  always #50 sys_clk = ~sys_clk;
  general_pin_port dut_u (.sys_clk, .rst, .avs_address(addr), .avs_read(rd), .avs_write(wr), .avs_writedata(wdata),
    .avs_byteenable(4'hF), .avs_readdata(rdata), .avs_waitrequest(wreq), .avs_response(resp),
    .general_purpose_pin_in(pin_in), .general_purpose_pin_out(pin_out), .general_purpose_pin_oe_n(oe_n), .irq);
  pin_far_end far_u (.ext_level(ext), .pin_out, .pin_oe_n(oe_n), .pin_in);
  // ***
  // helpers
  // ***
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [31:0] pins(input logic [15:0] d, s, e);
    return {16'h0000, (s & ~d) | (e & d)};
  endfunction
  task automatic chk(input string nm, input logic [31:0] s, e);
    checks_done++;
    if (s !== e) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    rd <= !w;
    wr <= w;
    addr <= a;
    wdata <= d;
    do @(posedge sys_clk); while (wreq !== 1'b0);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task automatic settle;
    repeat (8) @(posedge sys_clk);
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    #(100 * 3000);
    n_fail++;
    report_and_stop;
  end
  initial begin
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    for (int i = 0; i < 3; i++) begin
      bus(0, 12'h400 + 12'(4 * i), 32'h0);
      chk("reset", q, 32'h0);
    end
    $display("test reset done");
    for (int i = 0; i < 8; i++) begin
      seed = lfsr(seed);
      dir = (i == 0) ? 16'h0000 : (i == 1) ? 16'hFFFF : seed[15:0];
      bus(1, `OFF_PIN_DIRECTION, {seed[31:16], dir});
      seed = lfsr(seed);
      bus(1, `OFF_PIN_DATA, seed);
      stored = (stored & dir) | (seed[15:0] & ~dir);
      seed = lfsr(seed);
      ext <= seed[15:0];
      settle;
      bus(0, `OFF_PIN_DATA, 32'h0);
      chk("data", q, pins(dir, stored, ext));
      bus(0, `OFF_PIN_DIRECTION, 32'h0);
      chk("direction", q, {16'h0000, dir});
      chk("quiet irq", {31'h0, irq}, 32'h0);
    end
    $display("test data done");
    bus(1, `OFF_PIN_DIRECTION, 32'h0000FFFF);
    ext <= 16'h0000;
    settle;
    bus(1, `OFF_PIN_IRQ_ENABLE, 32'hFFFF0001);
    bus(0, `OFF_PIN_IRQ_ENABLE, 32'h0);
    chk("enable", q, 32'h1);
    ext <= 16'h0002;
    settle;
    chk("masked", {31'h0, irq}, 32'h0);
    ext <= 16'h0003;
    settle;
    chk("rise", {31'h0, irq}, 32'h1);
    bus(0, `OFF_PIN_IRQ_STATUS, 32'h0);
    chk("status", q, 32'h1);
    bus(1, `OFF_PIN_IRQ_CLEAR, 32'h1);
    settle;
    chk("cleared", {31'h0, irq}, 32'h0);
    ext <= 16'h0002;
    settle;
    chk("fall", {31'h0, irq}, 32'h1);
    bus(1, `OFF_PIN_IRQ_ENABLE, 32'h0);
    bus(1, `OFF_PIN_IRQ_CLEAR, 32'h1);
    ext <= 16'h0003;
    settle;
    chk("disabled", {31'h0, irq}, 32'h0);
    bus(0, 12'h500, 32'h0);
    chk("unmapped", q, 32'h0);
    chk("response", {30'h0, resp}, 32'h3);
    bus(1, 12'h500, 32'hFFFF_FFFF);
    chk("unmapped write", {30'h0, resp}, 32'h3);
    bus(0, `OFF_PIN_IRQ_ENABLE, 32'h0);
    chk("enable kept", q, 32'h0);
    $display("test irq done");
    report_and_stop;
  end
endmodule
`default_nettype wire
